// *** logic/cccd_pkg.sv ***
/*
 * Constants, register map and types shared by the card copy command
 * decoder. Assumes a 100 MHz system clock and an APB master with 32-bit data.
 */
`default_nettype none

package cccd_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CAP = 8'h0C;
    localparam logic [7:0] ADDR_DIFF = 8'h10;
    localparam logic [7:0] ADDR_FULL = 8'h14;
    localparam logic [7:0] ADDR_LEN = 8'h18;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_TRIG = 0;
    localparam int CTRL_CLR = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_TRIP = 1;
    localparam int ST_ERR = 2;
    localparam int ST_IGN = 3;
    localparam int ST_RO = 4;
    localparam int ST_WARN = 5;
    localparam int ST_PRESENT = 6;
    localparam int ST_DONE = 7;
    localparam logic [15:0] CODE_RST = 16'h0000;
    localparam logic [15:0] CAP_RST = 16'h0004;
    localparam logic [15:0] DIFF_RST = 16'h0000;
    localparam logic [19:0] FULL_RST = 20'h00000;

    // ------------------------------------------------------------
    // card geometry
    // ------------------------------------------------------------
    localparam logic [15:0] CAP_MIN_KB = 16'h0004;
    localparam logic [15:0] CAP_MAX_KB = 16'h0200;
    localparam logic [9:0] BLOCK_MIN = 10'h001;
    localparam logic [9:0] BLOCK_MAX = 10'h3E7;
    localparam logic [9:0] MACRO_FIRST = 10'h1F4;
    localparam logic [9:0] BOOT_BLOCK = 10'h001;
    localparam logic [19:0] BYTES_PER_DIFF = 20'h00006;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_WR_BOOT, OP_WR_FULL, OP_WR_DIFF, OP_WR_PROG, OP_RD_BLOCK,
        OP_ERASE_BLOCK, OP_COMPARE, OP_WARN_CLR, OP_WARN_SET, OP_RO_CLR,
        OP_RO_SET, OP_ERASE_ALL
    } cccd_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_REL} cccd_state_t;

endpackage

`default_nettype wire

// *** logic/cccd_sync.sv ***
/*
 * Two-flop synchroniser for card-side pins.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`default_nettype none

module cccd_sync
    import cccd_pkg::*;
#(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // cccd_sync

`default_nettype wire

// *** logic/cccd_decode.sv ***
/*
 * Combinational decode of a four-digit BCD command code.
 * Assumes the code is held stable in a register of the caller.
 */
`default_nettype none

module cccd_decode
    import cccd_pkg::*;
(
    input wire logic [15:0] code,
    output cccd_op_t op,
    output logic [9:0] block
);
    logic [3:0] lead;
    logic digits_ok;

    always_comb begin
        lead = code[15:12];
        digits_ok = (code[15:12] <= 4'h9) && (code[11:8] <= 4'h9)
            && (code[7:4] <= 4'h9) && (code[3:0] <= 4'h9);
        // lower three digits name the block
        block = 10'(10'(code[11:8]) * 10'h064 + 10'(code[7:4]) * 10'h00A
            + 10'(code[3:0]));
        op = OP_NONE;
        if (digits_ok && block >= BLOCK_MIN && block <= BLOCK_MAX) begin
            unique case (lead)
                4'h2: op = (code == 16'h2001) ? OP_WR_BOOT : OP_NONE;
                4'h3: op = OP_WR_FULL;
                4'h4: op = OP_WR_DIFF;
                4'h5: op = OP_WR_PROG;
                4'h6: op = OP_RD_BLOCK;
                4'h7: op = OP_ERASE_BLOCK;
                4'h8: op = OP_COMPARE;
                4'h9: begin
                    unique case (code)
                        16'h9555: op = OP_WARN_CLR;
                        16'h9666: op = OP_WARN_SET;
                        16'h9777: op = OP_RO_CLR;
                        16'h9888: op = OP_RO_SET;
                        16'h9999: op = OP_ERASE_ALL;
                        default: op = OP_NONE;
                    endcase
                end
                default: op = OP_NONE;
            endcase
        end
    end
endmodule // cccd_decode

`default_nettype wire

// *** logic/cccd_top.sv ***
/*
 * Card copy command decoder: APB registers, launch checks, card handshake,
 * removal trip and transfer indicator.
 * Assumes the card side answers a level request with a level done
 * (four-phase) and that card pins are asynchronous to clk_sys.
 */
// Chosen here: register access over APB and the register offsets.
// Function
// - a written code runs only when a drive reset follows the write
// - the lower three digits give a block number 001 to 999
// - code 2001 writes parameter differences to bootable block 001
// - leading digit 3 writes the full parameter set to the block
// - leading digit 4 writes parameter differences to the block
// - leading digit 5 writes the logic controller program to the block
// - leading digit 6 reads the block into the drive
// - leading digit 7 erases the block, 8 compares against it
// - 9555 clears and 9666 sets the warning suppression flag
// - 9777 clears and 9888 sets the card read-only flag
// - with read-only set, only block read and 9777 run
// - 9999 erases the whole card
// - blocks 1 to 499 writable, 999 block locations in all
// - blocks 500 to 999 are read-only macro blocks
// - cards from 4 kB to 512 kB are accepted
// - the card is touched only while a command runs
// - card removal during a transfer raises a trip
// - the decimal point flashes while a transfer is active
// - full and difference transfers exclude power-down-save parameters
// - difference transfers store six bytes per differing parameter
`default_nettype none

module cccd_top
    import cccd_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_present,
    input wire logic card_done,
    output logic card_req,
    output cccd_op_t card_op,
    output logic [9:0] card_block,
    output logic [19:0] card_len,
    output logic card_excl_pds,
    output logic trip,
    output logic dp_flash
);
    if (FLASH_CYCLES < 2) begin : g_bad_flash
        $error("FLASH_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // pin synchronisers and decode
    // ------------------------------------------------------------
    logic present_s;
    logic done_s;
    cccd_op_t dec_op;
    logic [9:0] dec_block;

    cccd_sync #(.W(2)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .d({card_present, card_done}),
        .q({present_s, done_s})
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] code;
    logic [15:0] cap_kb;
    logic [15:0] diff_cnt;
    logic [19:0] full_len;
    logic trig;
    logic err;
    logic ign;
    logic ro_flag;
    logic warn_flag;
    logic done_flag;
    cccd_state_t state;
    logic [15:0] next_code;
    logic [15:0] next_cap_kb;
    logic [15:0] next_diff_cnt;
    logic [19:0] next_full_len;
    logic next_trig;
    logic next_trip;
    logic next_err;
    logic next_ign;
    logic next_ro_flag;
    logic next_warn_flag;
    logic next_done_flag;
    cccd_state_t next_state;
    logic next_card_req;
    cccd_op_t next_card_op;
    logic [9:0] next_card_block;
    logic [19:0] next_card_len;
    logic next_card_excl_pds;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic wr_en;
    logic clr;
    logic busy;
    logic launch;
    logic writes_card;
    logic mapped;

    cccd_decode u_dec (
        .code(code),
        .op(dec_op),
        .block(dec_block)
    );

    always_comb begin
        busy = (state != ST_IDLE);
        wr_en = psel && penable && pready && pwrite;
        clr = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_CLR];
        writes_card = (dec_op == OP_WR_FULL) || (dec_op == OP_WR_DIFF)
            || (dec_op == OP_WR_PROG) || (dec_op == OP_ERASE_BLOCK);
        mapped = (paddr == ADDR_CODE) || (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
            || (paddr == ADDR_CAP) || (paddr == ADDR_DIFF) || (paddr == ADDR_FULL)
            || (paddr == ADDR_LEN);
        launch = 1'b0;
        next_ign = ign && !clr;
        next_err = err && !clr;
        next_state = state;
        next_card_req = card_req;
        next_card_op = card_op;
        next_card_block = card_block;
        next_card_len = card_len;
        next_card_excl_pds = card_excl_pds;
        next_trip = trip && !clr;
        next_ro_flag = ro_flag;
        next_warn_flag = warn_flag;
        next_done_flag = done_flag && !clr;
        unique case (state)
            ST_IDLE: begin
                // a command runs only on the drive reset after the code write
                if (trig) begin
                    if (dec_op == OP_NONE) begin
                        next_ign = 1'b1;
                    end else if (ro_flag && dec_op != OP_RD_BLOCK && dec_op != OP_RO_CLR) begin
                        next_ign = 1'b1;
                    end else if (writes_card && dec_block >= MACRO_FIRST) begin
                        next_err = 1'b1;
                    end else if (!present_s || cap_kb < CAP_MIN_KB || cap_kb > CAP_MAX_KB) begin
                        next_err = 1'b1;
                    end else begin
                        launch = 1'b1;
                        next_state = ST_REQ;
                        next_card_req = 1'b1;
                        next_card_op = dec_op;
                        next_card_block = (dec_op == OP_WR_BOOT) ? BOOT_BLOCK : dec_block;
                        next_card_excl_pds = (dec_op == OP_WR_BOOT) || (dec_op == OP_WR_FULL)
                            || (dec_op == OP_WR_DIFF);
                        if (dec_op == OP_WR_FULL) begin
                            next_card_len = full_len;
                        end else if (dec_op == OP_WR_DIFF || dec_op == OP_WR_BOOT) begin
                            next_card_len = 20'(20'(diff_cnt) * BYTES_PER_DIFF);
                        end else begin
                            next_card_len = 20'h00000;
                        end
                    end
                end
            end
            ST_REQ: begin
                if (done_s) begin
                    next_card_req = 1'b0;
                    next_state = ST_REL;
                    next_done_flag = 1'b1;
                    if (card_op == OP_RO_SET) next_ro_flag = 1'b1;
                    if (card_op == OP_RO_CLR) next_ro_flag = 1'b0;
                    if (card_op == OP_WARN_SET) next_warn_flag = 1'b1;
                    if (card_op == OP_WARN_CLR) next_warn_flag = 1'b0;
                end
            end
            ST_REL: begin
                if (!done_s) next_state = ST_IDLE;
            end
        endcase
        // removal mid-transfer aborts and trips; set wins over clear
        if (busy && !present_s) begin
            next_trip = 1'b1;
            next_card_req = 1'b0;
            next_state = ST_IDLE;
        end
    end

    always_comb begin
        next_code = code;
        next_cap_kb = cap_kb;
        next_diff_cnt = diff_cnt;
        next_full_len = full_len;
        // drive reset is a one-cycle pulse, ignored while a command runs
        next_trig = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_TRIG] && !busy;
        if (wr_en && !busy) begin
            if (paddr == ADDR_CODE) next_code = pwdata[15:0];
            if (paddr == ADDR_CAP) next_cap_kb = pwdata[15:0];
            if (paddr == ADDR_DIFF) next_diff_cnt = pwdata[15:0];
            if (paddr == ADDR_FULL) next_full_len = pwdata[19:0];
        end
        next_pready = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !mapped;
        next_prdata = prdata;
        if (psel && penable && !pready) begin
            next_prdata = 32'h00000000;
            unique case (paddr)
                ADDR_CODE: next_prdata[15:0] = code;
                ADDR_STATUS: begin
                    next_prdata[ST_BUSY] = busy;
                    next_prdata[ST_TRIP] = trip;
                    next_prdata[ST_ERR] = err;
                    next_prdata[ST_IGN] = ign;
                    next_prdata[ST_RO] = ro_flag;
                    next_prdata[ST_WARN] = warn_flag;
                    next_prdata[ST_PRESENT] = present_s;
                    next_prdata[ST_DONE] = done_flag;
                end
                ADDR_CAP: next_prdata[15:0] = cap_kb;
                ADDR_DIFF: next_prdata[15:0] = diff_cnt;
                ADDR_FULL: next_prdata[19:0] = full_len;
                ADDR_LEN: next_prdata[19:0] = card_len;
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            code <= CODE_RST;
            cap_kb <= CAP_RST;
            diff_cnt <= DIFF_RST;
            full_len <= FULL_RST;
            trig <= 1'b0;
            trip <= 1'b0;
            err <= 1'b0;
            ign <= 1'b0;
            ro_flag <= 1'b0;
            warn_flag <= 1'b0;
            done_flag <= 1'b0;
            state <= ST_IDLE;
            card_req <= 1'b0;
            card_op <= OP_NONE;
            card_block <= 10'h000;
            card_len <= 20'h00000;
            card_excl_pds <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            code <= next_code;
            cap_kb <= next_cap_kb;
            diff_cnt <= next_diff_cnt;
            full_len <= next_full_len;
            trig <= next_trig;
            trip <= next_trip;
            err <= next_err;
            ign <= next_ign;
            ro_flag <= next_ro_flag;
            warn_flag <= next_warn_flag;
            done_flag <= next_done_flag;
            state <= next_state;
            card_req <= next_card_req;
            card_op <= next_card_op;
            card_block <= next_card_block;
            card_len <= next_card_len;
            card_excl_pds <= next_card_excl_pds;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // transfer indicator
    // ------------------------------------------------------------
    // a slow blink so an operator can see it; counter is idle otherwise
    logic [31:0] flash_cnt;
    logic [31:0] next_flash_cnt;
    logic next_dp_flash;

    always_comb begin
        next_flash_cnt = 32'h00000000;
        next_dp_flash = 1'b0;
        if (busy) begin
            next_dp_flash = dp_flash;
            next_flash_cnt = flash_cnt + 32'h00000001;
            if (flash_cnt >= 32'(FLASH_CYCLES - 1)) begin
                next_flash_cnt = 32'h00000000;
                next_dp_flash = !dp_flash;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt <= 32'h00000000;
            dp_flash <= 1'b0;
        end else if (ce) begin
            flash_cnt <= next_flash_cnt;
            dp_flash <= next_dp_flash;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_launch;
        ce && launch;
    endsequence
    sequence s_req_up;
        card_req && card_op != OP_NONE;
    endsequence

    property p_trig_before;
        ce && launch |-> $past(ce && wr_en && paddr == ADDR_CTRL && pwdata[CTRL_TRIG], 1);
    endproperty
    a_trig_before: assert property (p_trig_before) else $error("launch without reset");

    property p_block_range;
        s_launch |=> s_req_up and (card_block >= BLOCK_MIN && card_block <= BLOCK_MAX);
    endproperty
    a_block_range: assert property (p_block_range) else $error("bad block");

    property p_boot_block;
        s_launch ##0 (dec_op == OP_WR_BOOT) |=> card_block == 10'h001 && card_excl_pds;
    endproperty
    a_boot_block: assert property (p_boot_block) else $error("boot not block 1");

    property p_ro_gate;
        s_launch ##0 ro_flag |-> dec_op == OP_RD_BLOCK || dec_op == OP_RO_CLR;
    endproperty
    a_ro_gate: assert property (p_ro_gate) else $error("ro flag ignored");

    property p_macro;
        ce && trig && !busy && writes_card && dec_block >= 10'h1F4 && !(ro_flag)
            |=> err && !card_req;
    endproperty
    a_macro: assert property (p_macro) else $error("macro block written");

    property p_cap;
        s_launch |-> cap_kb >= 16'h0004 && cap_kb <= 16'h0200;
    endproperty
    a_cap: assert property (p_cap) else $error("card size out of range");

    property p_req_busy;
        card_req |-> busy;
    endproperty
    a_req_busy: assert property (p_req_busy) else $error("card touched idle");

    property p_removal;
        ce && busy && !present_s |=> trip && !card_req && !busy;
    endproperty
    a_removal: assert property (p_removal) else $error("no trip on removal");

    property p_dp_idle;
        !busy ##1 !busy |-> !dp_flash;
    endproperty
    a_dp_idle: assert property (p_dp_idle) else $error("indicator while idle");

    property p_diff_len;
        s_launch ##0 (dec_op == OP_WR_DIFF) |=> card_len == 20'(20'($past(diff_cnt)) * 20'h00006)
            && card_excl_pds;
    endproperty
    a_diff_len: assert property (p_diff_len) else $error("diff length wrong");

endmodule // cccd_top

`default_nettype wire

// *** sim/cccd_card_model.sv ***
/*
 * Card-side model: answers each level request with a level done after a
 * programmable number of clk_sys cycles, four-phase.
 * Assumes the request comes from the decoder and lat is held per command.
 */
`default_nettype none

module cccd_card_model (
    input wire logic clk_sys,
    input wire logic card_req,
    input wire logic [7:0] lat,
    output logic card_done
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt = 0;

    initial card_done = 1'b0;

    // ------------------------------------------------------------
    // four-phase answer
    // ------------------------------------------------------------
    // the card acts only on a request, and lets go once it is dropped
    always @(posedge clk_sys) begin
        if (card_req && !card_done) begin
            cnt <= cnt + 1;
            if (cnt >= lat) card_done <= 1'b1;
        end else if (!card_req) begin
            cnt <= 0;
            card_done <= 1'b0;
        end
    end
endmodule // cccd_card_model

`default_nettype wire

// *** sim/card_copy_command_decoder_tb.sv ***
/*
 * Self-checking bench for the card copy command decoder.
 * Assumes an APB slave with one wait state and a four-phase card link.
 */
`default_nettype none

module card_copy_command_decoder_tb
    import cccd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, lat = 8'h02;
    logic [31:0] pwdata = 0, prdata, rq;
    logic pready, pslverr, re, card_present = 1, card_done, card_req;
    logic card_excl_pds, trip, dp_flash;
    cccd_op_t card_op;
    logic [9:0] card_block;
    logic [19:0] card_len, full_v, diff_v;
    int n_fail = 0, n_tests = 0, d, n_dp = 0;

    always #5 clk_sys = ~clk_sys;
    // counts cycles with the indicator lit; one driver, sampled before and after a transfer
    always @(posedge clk_sys) if (dp_flash === 1'b1) n_dp <= n_dp + 1;

    cccd_top #(.FLASH_CYCLES(4)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_present(card_present),
        .card_done(card_done), .card_req(card_req), .card_op(card_op),
        .card_block(card_block), .card_len(card_len), .card_excl_pds(card_excl_pds),
        .trip(trip), .dp_flash(dp_flash));
    cccd_card_model u_card (.clk_sys(clk_sys), .card_req(card_req), .lat(lat),
        .card_done(card_done));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic close_out;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dv;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rq = prdata;
        re = pslverr;
        chk(k < 20, "no pready");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    function automatic cccd_op_t xop(input logic [15:0] c);
        case (c)
            16'h2001: return OP_WR_BOOT;
            16'h9555: return OP_WARN_CLR;
            16'h9666: return OP_WARN_SET;
            16'h9777: return OP_RO_CLR;
            16'h9888: return OP_RO_SET;
            16'h9999: return OP_ERASE_ALL;
            default: return cccd_op_t'(c[15:12] - 4'h1);
        endcase
    endfunction

    function automatic logic [19:0] xlen(input cccd_op_t op);
        if (op == OP_WR_FULL) return full_v;
        if (op == OP_WR_DIFF || op == OP_WR_BOOT) return diff_v * BYTES_PER_DIFF;
        return 20'h0;
    endfunction

    function automatic logic [9:0] xblk(input logic [15:0] c);
        int v;
        v = c[11:8] * 100 + c[7:4] * 10 + c[3:0];
        return v[9:0];
    endfunction

    function automatic logic [11:0] bcd(input int b);
        return {4'(b / 100), 4'((b / 10) % 10), 4'(b % 10)};
    endfunction

    // kind: 0 launches, 1 is ignored, 2 is refused with an error
    task automatic go(input logic [15:0] c, input int kind);
        int k;
        cccd_op_t op;
        op = xop(c);
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_CODE, {16'h0, c});
        chk(card_req === 1'b0, "request before trigger");
        apb(1'b1, ADDR_CTRL, 32'h1);
        k = 0;
        while (card_req !== 1'b1 && k < 8) begin
            @(posedge clk_sys);
            k++;
        end
        if (kind == 0) begin
            chk(card_op === op && card_len === xlen(op), "op or length");
            if (c[15:12] < 4'h9) chk(card_block === xblk(c), "block");
            chk(card_excl_pds === (c[15:12] inside {4'h2, 4'h3, 4'h4}), "excl");
        end else chk(card_req === 1'b0, "refused code launched");
        k = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            k++;
        end while (rq[ST_BUSY] !== 1'b0 && k < 60);
        chk(rq[kind == 0 ? ST_DONE : kind == 1 ? ST_IGN : ST_ERR] === 1'b1, "status");
        chk(dp_flash === 1'b0, "flash when idle");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        void'($urandom(32'h8E73E38B));
        apb(1'b0, ADDR_CAP, 32'h0);
        chk(rq === {16'h0, CAP_RST}, "cap reset");
        apb(1'b0, 8'hFC, 32'h0);
        chk(re === 1'b1 && rq === 32'h0, "unmapped");
        full_v = 20'($urandom_range(1, 20'hFFFFF));
        diff_v = 20'($urandom_range(1, 1000));
        apb(1'b1, ADDR_FULL, {12'h0, full_v});
        apb(1'b1, ADDR_DIFF, {12'h0, diff_v});
        go(16'h2001, 0);
        for (d = 3; d <= 8; d++) go({d[3:0], bcd($urandom_range(1, 499))}, 0);
        go(16'h3001, 0);
        go(16'h4499, 0);
        go(16'h6999, 0);
        go(16'h3500, 2);
        go(16'h7999, 2);
        go(16'h1234, 1);
        go(16'h5000, 1);
        go(16'h9666, 0);
        chk(rq[ST_WARN] === 1'b1, "warn set");
        go(16'h9555, 0);
        chk(rq[ST_WARN] === 1'b0, "warn clear");
        go(16'h9888, 0);
        chk(rq[ST_RO] === 1'b1, "read-only set");
        go(16'h4123, 1);
        go(16'h9999, 1);
        go(16'h6123, 0);
        go(16'h9777, 0);
        chk(rq[ST_RO] === 1'b0, "read-only clear");
        go(16'h9999, 0);
        apb(1'b1, ADDR_CAP, 32'h3);
        go(16'h3010, 2);
        apb(1'b1, ADDR_CAP, 32'h200);
        lat <= 8'h28;
        d = n_dp;
        go(16'h3010, 0);
        chk(n_dp > d, "no flash in transfer");
        apb(1'b0, ADDR_LEN, 32'h0);
        chk(rq === {12'h0, full_v}, "length readback");
        lat <= 8'hC8;
        apb(1'b1, ADDR_CODE, 32'h3002);
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (4) @(posedge clk_sys);
        card_present <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(trip === 1'b1 && card_req === 1'b0, "no trip on removal");
        close_out();
    end

    initial begin
        #400000;
        n_fail++;
        close_out();
    end
endmodule // card_copy_command_decoder_tb

`default_nettype wire
